// [include/acps_pkg.sv]
`default_nettype none
package acps_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
    localparam int unsigned CONV_ANA_NS     = 9_000;
    localparam int unsigned CONV_TEMP_NS    = 27_000;
    localparam int unsigned PWRUP_NS        = 2_000;
    localparam int unsigned CONV_ANA_CYC    = CONV_ANA_NS / CLK_PERIOD_NS;
    localparam int unsigned CONV_TEMP_CYC   = CONV_TEMP_NS / CLK_PERIOD_NS;
    localparam int unsigned PWRUP_CYC       =
        (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W           = 10;
    localparam int unsigned DATA_W          = 10;
    localparam int unsigned SAR_STEPS       = 10;
    localparam int unsigned CHAN_W          = 3;
    localparam logic [2:0]  CHAN_TEMP       = 3'h0;
    localparam logic [2:0]  CHAN_VREF       = 3'h7;
    localparam logic [9:0]  CODE_ZERO       = 10'h000;
    localparam logic [9:0]  CODE_MIDSCALE   = 10'h200;
    localparam logic [9:0]  TEMP_CODE_M55   = 10'h0C0;
    localparam logic [9:0]  TEMP_CODE_P125  = 10'h390;
    localparam int          TEMP_OFFSET_C   = -103;
    localparam int unsigned TEMP_FRAC_BITS  = 2;
    typedef logic [DATA_W-1:0] acps_code_t;
    typedef logic [CHAN_W-1:0] acps_chan_t;
    typedef enum logic [3:0] {
        ACPS_TRACK = 4'h1,
        ACPS_CONV  = 4'h2,
        ACPS_DOWN  = 4'h4,
        ACPS_PWRUP = 4'h8
    } acps_state_t;
endpackage
`default_nettype wire

// [hdl/acps_sync.sv]
`default_nettype none
module acps_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    // async level in, synced level out
    input  wire logic async_i,
    output var  logic sync_o
);
    logic meta_reg;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            meta_reg <= RESET_VAL;
            sync_o   <= RESET_VAL;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// [hdl/acps_sar.sv]
`default_nettype none
module acps_sar
    import acps_pkg::*;
#(
    parameter int unsigned W = acps_pkg::DATA_W
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         sys_rst_i,
    // control
    input  wire logic         start_i,
    input  wire logic         step_i,
    input  wire logic         cmp_i,
    // result in progress
    output var  logic [W-1:0] trial_o,
    output var  logic         done_o
);
    logic [W-1:0] bit_reg;
    logic [W-1:0] acc_reg;
    // trial = bits kept so far plus the bit under test
    assign trial_o = acc_reg | bit_reg;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            bit_reg <= '0;
            acc_reg <= '0;
            done_o  <= 1'b0;
        end else if (start_i) begin
            bit_reg <= {1'b1, {(W-1){1'b0}}};
            acc_reg <= '0;
            done_o  <= 1'b0;
        end else if (step_i && bit_reg != '0) begin
            if (cmp_i) begin
                acc_reg <= acc_reg | bit_reg;
            end
            bit_reg <= bit_reg >> 1;
            done_o  <= (bit_reg[0] == 1'b1);
        end
    end
endmodule
`default_nettype wire

// [hdl/acps_sequencer.sv]
// Summary of operation
// - track after a conversion that ends with start high, hold on start fall
// - result is straight binary, LSB ref/1024
// - channel 000 is temperature, power-on default
// - temperature equals code/4 minus 103
// - temperature codes 0C0 at -55, 390 at 125
// - mode chosen by start level at end
// - start high before busy falls: stay powered
// - start still low at end: power down
// - power up on next start rising edge
// - analog conversion completes within 9 us
// - busy high 9 us analog, 27 us temp
`default_nettype none
module acps_sequencer
    import acps_pkg::*;
#(
    parameter int unsigned CONV_ANA  = acps_pkg::CONV_ANA_CYC,
    parameter int unsigned CONV_TEMP = acps_pkg::CONV_TEMP_CYC,
    parameter int unsigned PWRUP     = acps_pkg::PWRUP_CYC
) (
    // clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                sys_rst_i,
    // host pins
    input  wire logic                convert_start_n_i,
    output var  logic                busy_o,
    // channel selection from the serial port
    input  wire acps_pkg::acps_chan_t chan_sel_i,
    input  wire logic                chan_wr_i,
    // comparator from the analog core
    input  wire logic                cmp_i,
    // analog controls and result
    output var  logic                track_o,
    output var  logic                powered_o,
    output var  acps_pkg::acps_chan_t chan_o,
    output var  acps_pkg::acps_code_t trial_o,
    output var  acps_pkg::acps_code_t result_o,
    output var  logic                result_valid_o
);
    import acps_pkg::*;

    localparam int unsigned STEP_DIV = CONV_ANA / SAR_STEPS;

    logic            start_n_sync;
    logic            start_n_prev_reg;
    logic            start_fall;
    logic            start_rise;
    acps_state_t     state_reg;
    logic [CNT_W:0]  cnt_reg;
    logic [CNT_W:0]  conv_len_reg;
    logic [CNT_W:0]  step_cnt_reg;
    logic            sar_start;
    logic            sar_step;
    logic            sar_done;
    acps_code_t      sar_trial;
    logic            conv_end;

    acps_sync #(.RESET_VAL(1'b1)) u_sync (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .async_i    (convert_start_n_i),
        .sync_o     (start_n_sync)
    );

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            start_n_prev_reg <= 1'b1;
        end else begin
            start_n_prev_reg <= start_n_sync;
        end
    end
    assign start_fall = start_n_prev_reg & ~start_n_sync;
    assign start_rise = ~start_n_prev_reg & start_n_sync;

    // a fall that is only seen during conversion is dropped, never queued
    assign sar_start = start_fall && state_reg == ACPS_TRACK;
    assign conv_end  = state_reg == ACPS_CONV && cnt_reg == conv_len_reg;

    // state machine
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= ACPS_TRACK;
        end else begin
            unique case (state_reg)
                ACPS_TRACK: begin
                    if (sar_start) begin
                        state_reg <= ACPS_CONV;
                    end
                end
                ACPS_CONV: begin
                    if (conv_end) begin
                        // level of start at end picks the mode
                        if (!start_n_sync) begin
                            state_reg <= ACPS_DOWN;
                        end else begin
                            state_reg <= ACPS_TRACK;
                        end
                    end
                end
                ACPS_DOWN: begin
                    if (start_rise) begin
                        state_reg <= ACPS_PWRUP;
                    end
                end
                ACPS_PWRUP: begin
                    if (cnt_reg == (CNT_W+1)'(PWRUP - 1)) begin
                        state_reg <= ACPS_TRACK;
                    end
                end
            endcase
        end
    end

    // cycle counter shared by conversion and power-up
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
        end else if (sar_start || (state_reg == ACPS_DOWN && start_rise)) begin
            cnt_reg <= '0;
        end else if (state_reg == ACPS_CONV || state_reg == ACPS_PWRUP) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // conversion length latched at start, temperature is the slow one
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            conv_len_reg <= (CNT_W+1)'(CONV_TEMP - 1);
        end else if (sar_start) begin
            if (chan_o == CHAN_TEMP) begin
                conv_len_reg <= (CNT_W+1)'(CONV_TEMP - 1);
            end else begin
                conv_len_reg <= (CNT_W+1)'(CONV_ANA - 1);
            end
        end
    end

    // channel register; a write during conversion waits no turn, it
    // simply takes effect for the next one since length is latched
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            chan_o <= CHAN_TEMP;
        end else if (chan_wr_i) begin
            chan_o <= chan_sel_i;
        end
    end

    // bit-step pacing: all bits decided within the analog time
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || sar_start) begin
            step_cnt_reg <= '0;
        end else if (state_reg == ACPS_CONV) begin
            if (step_cnt_reg == (CNT_W+1)'(STEP_DIV - 1)) begin
                step_cnt_reg <= '0;
            end else begin
                step_cnt_reg <= step_cnt_reg + 1'b1;
            end
        end
    end
    assign sar_step = state_reg == ACPS_CONV &&
                      step_cnt_reg == (CNT_W+1)'(STEP_DIV - 1);

    // plain binary search: code n means input between n and n+1 LSB
    acps_sar #(.W(DATA_W)) u_sar (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .start_i    (sar_start),
        .step_i     (sar_step),
        .cmp_i      (cmp_i),
        .trial_o    (sar_trial),
        .done_o     (sar_done)
    );
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            trial_o <= CODE_ZERO;
        end else begin
            trial_o <= sar_trial;
        end
    end

    // result replaced only at the end so reads never see partial codes;
    // temperature codes are the same binary search on the sensor voltage
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            result_o       <= CODE_ZERO;
            result_valid_o <= 1'b0;
        end else if (conv_end) begin
            // the lowest bit can be settled on this very edge; a refused
            // trial there is the trial minus the bit just tried
            if (sar_step && !sar_done && !cmp_i) begin
                result_o <= sar_trial - 1'b1;
            end else begin
                result_o <= sar_trial;
            end
            result_valid_o <= 1'b1;
        end
    end

    // pin-facing outputs
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            busy_o    <= 1'b0;
            track_o   <= 1'b1;
            powered_o <= 1'b1;
        end else begin
            busy_o    <= (state_reg == ACPS_TRACK && sar_start) ||
                         (state_reg == ACPS_CONV && !conv_end);
            track_o   <= (state_reg == ACPS_CONV && conv_end &&
                          start_n_sync) ||
                         (state_reg == ACPS_TRACK && !sar_start) ||
                         (state_reg == ACPS_PWRUP);
            powered_o <= !(state_reg == ACPS_CONV && conv_end &&
                           !start_n_sync) &&
                         !(state_reg == ACPS_DOWN && !start_rise);
        end
    end

    // checks
    sequence s_fall_taken;
        state_reg == ACPS_TRACK && start_fall;
    endsequence
    sequence s_busy_ana;
        busy_o [*8];
    endsequence

    property p_busy_rises;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        s_fall_taken |=> busy_o && !track_o;
    endproperty
    a_busy_rises: assert property (p_busy_rises)
        else $error("busy did not rise on start fall");

    property p_busy_holds;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        s_fall_taken |=> s_busy_ana;
    endproperty
    a_busy_holds: assert property (p_busy_holds)
        else $error("busy dropped early");

    // busy cycles counted here, judged against the latched length
    logic [CNT_W:0]  busy_run_reg;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !busy_o) begin
            busy_run_reg <= '0;
        end else begin
            busy_run_reg <= busy_run_reg + 1'b1;
        end
    end

    property p_busy_len;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        $fell(busy_o) |-> busy_run_reg == conv_len_reg + 1'b1;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length differs from channel time");

    property p_ana_len;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (s_fall_taken and chan_o != CHAN_TEMP)
            |=> ##[1:180] !busy_o;
    endproperty
    a_ana_len: assert property (p_ana_len)
        else $error("analog conversion exceeded its time");

    property p_ignore;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        state_reg == ACPS_CONV && start_fall && !conv_end
            |=> state_reg == ACPS_CONV && cnt_reg == $past(cnt_reg) + 1'b1;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("start fall disturbed a conversion");

    property p_result;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !conv_end |=> $stable(result_o);
    endproperty
    a_result: assert property (p_result)
        else $error("result changed outside conversion end");

    property p_pdown;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        conv_end && !start_n_sync |=> !powered_o && !busy_o;
    endproperty
    a_pdown: assert property (p_pdown)
        else $error("no power down with start low at end");

    property p_stay;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        conv_end && start_n_sync |=> powered_o && track_o;
    endproperty
    a_stay: assert property (p_stay)
        else $error("powered down with start high at end");

    property p_mode;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        conv_end |=> (state_reg == ACPS_DOWN) == !$past(start_n_sync);
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode not chosen by start level");

    property p_wake;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        state_reg == ACPS_DOWN && start_rise |=> ##[1:60] powered_o;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no power up after start rise");

    property p_temp_default;
        @(posedge core_clk_i)
        $past(sys_rst_i) && !chan_wr_i |-> chan_o == CHAN_TEMP;
    endproperty
    a_temp_default: assert property (p_temp_default)
        else $error("channel not temperature after reset");
endmodule
`default_nettype wire

// [sim/acps_host.sv]
`default_nettype none
module acps_host (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // device pins
    input  wire logic busy_i,
    output var  logic conv_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // two cycles at 50 ns cover the settling after an end of conversion
    localparam int GAP = 2;
    int quiet;

    initial conv_n_o = 1'b1;

    always @(posedge clk_i) begin
        quiet <= (rst_i || busy_i) ? 0 : quiet + 1;
    end

    // rude skips the quiet-time wait, only for the ignored-start case
    task automatic low(input bit rude, output bit late);
        int n = 0;
        while (!rude && quiet < GAP && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        late = (n >= 100);
        @(posedge clk_i);
        conv_n_o <= 1'b0;
    endtask

    task automatic high();
        @(posedge clk_i);
        conv_n_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import acps_pkg::*;
    localparam int unsigned CONV_A = 20;
    localparam int unsigned CONV_T = 60;
    localparam int unsigned PWR    = 4;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       conv_n;
    logic       busy, track, powered, valid, cmp, wr = 1'b0;
    acps_chan_t sel = 3'h0;
    acps_chan_t chan;
    acps_code_t trial, result;
    acps_code_t vin = 10'h000;
    logic [15:0] run = 16'h0000;
    logic [15:0] last_w = 16'h0000;
    int error_cnt = 0;
    int tests_run = 0;

    always #25 clk = ~clk;
    // comparator stands in for the analog core
    assign cmp = (vin >= trial);
    always @(posedge clk) begin
        if (busy) run <= run + 16'h0001;
        else begin
            if (run != 16'h0000) last_w <= run;
            run <= 16'h0000;
        end
    end

    acps_sequencer #(.CONV_ANA(CONV_A), .CONV_TEMP(CONV_T), .PWRUP(PWR))
    u_dut (
        .core_clk_i(clk), .sys_rst_i(rst), .convert_start_n_i(conv_n),
        .busy_o(busy), .chan_sel_i(sel), .chan_wr_i(wr), .cmp_i(cmp),
        .track_o(track), .powered_o(powered), .chan_o(chan),
        .trial_o(trial), .result_o(result), .result_valid_o(valid)
    );
    acps_host u_host (.clk_i(clk), .rst_i(rst), .busy_i(busy),
                      .conv_n_o(conv_n));

    task automatic summarize();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic hang();
        chk(16'h0000, 16'h0001);
        summarize();
    endtask

    task automatic pick(input acps_chan_t c);
        @(posedge clk);
        sel <= c;
        wr  <= 1'b1;
        @(posedge clk);
        wr  <= 1'b0;
        @(negedge clk);
    endtask

    // one conversion; hold keeps start low past the end
    task automatic conv(input acps_code_t v, input bit hold, input bit rude);
        acps_code_t prev;
        int n = 0;
        bit late;
        prev = result;
        @(posedge clk);
        vin <= v;
        u_host.low(1'b0, late);
        if (late) hang();
        while (busy !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (n >= 10) hang();
        chk(16'(track), 16'h0000);
        repeat (3) @(posedge clk);
        if (!hold) u_host.high();
        if (rude) begin
            u_host.low(1'b1, late);
            repeat (2) @(posedge clk);
            u_host.high();
        end
        @(negedge clk);
        chk(16'(result), 16'(prev));
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) hang();
        chk(16'(powered), hold ? 16'h0000 : 16'h0001);
        chk(16'(track), hold ? 16'h0000 : 16'h0001);
        chk(16'(result), 16'(v));
        chk(16'(valid), 16'h0001);
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_reset();
        chk(16'(chan), 16'(CHAN_TEMP));
        chk({busy, track, powered, valid}, 16'h0006);
        chk(16'(result), 16'(CODE_ZERO));
    endtask

    task automatic t_analog();
        acps_code_t codes[3] = '{10'h000, 10'h3FF, 10'h2A5};
        pick(3'h1);
        foreach (codes[i]) begin
            conv(codes[i], 1'b0, 1'b0);
            chk(last_w, 16'(CONV_A));
        end
    endtask

    task automatic t_temp();
        int temps[3] = '{-55, 25, 125};
        acps_code_t code;
        pick(CHAN_TEMP);
        chk(16'(chan), 16'(CHAN_TEMP));
        foreach (temps[i]) begin
            code = 10'((temps[i] + 103) * 4);
            conv(code, 1'b0, 1'b0);
            chk(last_w, 16'(CONV_T));
        end
    endtask

    task automatic t_ignored();
        pick(3'h1);
        conv(10'h155, 1'b0, 1'b1);
        chk(last_w, 16'(CONV_A));
        repeat (10) @(negedge clk);
        chk(16'(busy), 16'h0000);
    endtask

    task automatic t_powerdown();
        int n = 0;
        conv(10'h0AA, 1'b1, 1'b0);
        repeat (PWRUP_CYC) @(negedge clk);
        chk(16'(powered), 16'h0000);
        u_host.high();
        while (powered !== 1'b1 && n < 3 + PWR + 8) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3 + PWR + 8) hang();
        chk(16'(powered), 16'h0001);
        repeat (4) @(negedge clk);
        chk(16'(track), 16'h0001);
        conv(10'h321, 1'b0, 1'b0);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_analog();
        t_temp();
        t_ignored();
        t_powerdown();
        summarize();
    end
endmodule
`default_nettype wire
